/* src/fspg_pkg.sv */
// flash status and protection guard: shared constants, types, decoders
// assumes a 32-bit axi4-lite slave with 8-bit registers in the low byte
`default_nettype none
package fspg_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int unsigned AXI_AW   = 8;
  localparam int unsigned AXI_DW   = 32;
  localparam int unsigned REG_W    = 8;
  localparam int unsigned IDX_W    = 4;
  localparam int unsigned ADDR_LSB = 2;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [IDX_W-1:0] IDX_CFG  = 4'h3;
  localparam logic [IDX_W-1:0] IDX_PROT = 4'h4;
  localparam logic [IDX_W-1:0] IDX_STAT = 4'h5;
  localparam logic [IDX_W-1:0] IDX_CMD  = 4'h6;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned B_BEF   = 7;
  localparam int unsigned B_CDONE = 6;
  localparam int unsigned B_PROTECTION_VIOLATION_FLAG = 5;
  localparam int unsigned B_ACC   = 4;
  localparam int unsigned B_BLANK = 2;
  localparam int unsigned B_FAIL  = 1;
  localparam int unsigned B_IDLE  = 0;
  localparam int unsigned B_BEIE  = 7;
  localparam int unsigned B_CDIE  = 6;
  localparam int unsigned B_OPEN  = 7;
  localparam int unsigned B_HDIS  = 5;
  localparam int unsigned B_LDIS  = 2;

  // ****************************************************************
  // command codes and protection tables
  // ****************************************************************
  localparam logic [REG_W-1:0] CMD_VERIFY = 8'h05;
  localparam logic [REG_W-1:0] CMD_PROG   = 8'h20;
  localparam logic [REG_W-1:0] CMD_SECTOR = 8'h40;
  localparam logic [REG_W-1:0] CMD_MASS   = 8'h41;
  localparam logic [REG_W-1:0] CMD_MASK   = 8'h65;
  // allowed targets for source scenarios 0..5, row n in bits [8n+7:8n]
  localparam logic [47:0] TRANS_FIXED = {8'h3C, 8'h18, 8'h08, 8'h0C, 8'h0A, 8'h0F};

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_ADDR = 2'h1,
    SEQ_CMD  = 2'h3
  } fspg_seq_t;

  // mapped register indices
  function automatic logic fspg_reg_hit(input logic [IDX_W-1:0] idx);
    return idx inside {IDX_CFG, IDX_PROT, IDX_STAT, IDX_CMD};
  endfunction

  // protection byte to scenario number 0..7
  function automatic logic [2:0] fspg_scenario(input logic [REG_W-1:0] p);
    return {~p[B_OPEN], ~p[B_HDIS], ~p[B_LDIS]};
  endfunction

endpackage
`default_nettype wire

/* src/fspg_reg_if.sv */
// register access strobes between the bus slave and the status core
// assumes all users sit on one clock; carries no clock of its own
`timescale 1ns/1ps
`default_nettype none
interface fspg_reg_if;
  logic       wr;
  logic       rd;
  logic [3:0] idx_w;
  logic [3:0] idx_r;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport slave (output wr, rd, idx_w, idx_r, wdata, input rdata);
  modport core  (input wr, rd, idx_w, idx_r, wdata, output rdata);
endinterface
`default_nettype wire

/* src/fspg_prot_filter.sv */
// protection configuration register with its transition filter
// assumes wr_en is a one-cycle strobe on the same clock
`timescale 1ns/1ps
`default_nettype none
module fspg_prot_filter import fspg_pkg::*; #(
  parameter logic [REG_W-1:0] PROT_RESET = 8'hFF,
  parameter logic [15:0]      TRANS_HI   = 16'h8848
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  // write port
  input  wire logic             wr_en,
  input  wire logic [REG_W-1:0] wdata,
  // state
  output logic      [REG_W-1:0] prot_q,
  output logic                  allowed
);

  typedef struct packed {
    logic [REG_W-1:0] prot;
  } fspg_pf_t;

  fspg_pf_t s_q, s_d;
  logic [63:0] mask;

  // ****************************************************************
  // transition check
  // ****************************************************************
  // rows 6 and 7 come from a parameter so they can be set per part
  assign mask    = {TRANS_HI, TRANS_FIXED};
  assign allowed = mask[{fspg_scenario(s_q.prot), fspg_scenario(wdata)}];
  assign prot_q  = s_q.prot;

  // a refused write leaves the register untouched
  always_comb begin
    s_d = s_q;
    if (wr_en && allowed) begin
      s_d.prot = wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '{prot: PROT_RESET};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

endmodule
`default_nettype wire

/* src/fspg_axil_slave.sv */
// axi4-lite slave that turns bus transfers into register strobes
// assumes one outstanding write and one outstanding read
`timescale 1ns/1ps
`default_nettype none
module fspg_axil_slave import fspg_pkg::*; (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // write channels
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [AXI_AW-1:0] awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [AXI_DW-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic      [1:0]        bresp,
  // read channels
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [AXI_AW-1:0] araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic      [AXI_DW-1:0] rdata,
  output logic      [1:0]        rresp,
  // register strobes
  fspg_reg_if.slave              rb
);

  typedef struct packed {
    logic             have_aw;
    logic             have_w;
    logic [IDX_W-1:0] aidx;
    logic [REG_W-1:0] wdat;
    logic             wen;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [REG_W-1:0] rdat;
    logic [1:0]       rresp;
  } fspg_ax_t;

  fspg_ax_t s_q, s_d;
  logic     do_wr;

  // ****************************************************************
  // handshakes and strobes
  // ****************************************************************
  // address and data are held until the response is taken
  assign awready  = ce && !s_q.have_aw && !s_q.bvalid;
  assign wready   = ce && !s_q.have_w && !s_q.bvalid;
  assign arready  = ce && !s_q.rvalid;
  assign do_wr    = ce && s_q.have_aw && s_q.have_w && !s_q.bvalid;
  assign rb.wr    = do_wr && s_q.wen && fspg_reg_hit(s_q.aidx);
  assign rb.idx_w = s_q.aidx;
  assign rb.wdata = s_q.wdat;
  assign rb.rd    = arvalid && arready;
  assign rb.idx_r = araddr[ADDR_LSB +: IDX_W];

  always_comb begin
    s_d = s_q;
    if (awvalid && awready) begin
      s_d.have_aw = 1'b1;
      s_d.aidx    = awaddr[ADDR_LSB +: IDX_W];
    end
    if (wvalid && wready) begin
      s_d.have_w = 1'b1;
      s_d.wdat   = wdata[REG_W-1:0];
      s_d.wen    = wstrb[0];
    end
    if (do_wr) begin
      s_d.have_aw = 1'b0;
      s_d.have_w  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = fspg_reg_hit(s_q.aidx) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (rb.rd) begin
      s_d.rvalid = 1'b1;
      s_d.rdat   = rb.rdata;
      s_d.rresp  = fspg_reg_hit(rb.idx_r) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign bvalid = s_q.bvalid;
  assign bresp  = s_q.bresp;
  assign rvalid = s_q.rvalid;
  assign rdata  = AXI_DW'(s_q.rdat);
  assign rresp  = s_q.rresp;

endmodule
`default_nettype wire

/* src/fspg_top.sv */
// flash status and protection guard: status flags, launch gate, registers
// assumes the program/erase engine shares aclk and gives one-cycle pulses
//
// What this block does
// - refused protection writes leave register unchanged
// - protection register reads show scenario in force
// - fixed transition table for scenarios 0 to 5
// - normal mode status bit access per field
// - special mode exposes verify-error and idle
// - buffer-empty flag set when free, write-one clears
// - zero to buffer-empty mid-sequence aborts, flags error
// - buffer-empty and its enable raise interrupt
// - command-done clears on launch, sets when all done
// - command-done and its enable raise interrupt
// - protected program/erase sets violation, write-one clears
// - violation flag blocks command launch
// - sequence, illegal command, stop set access error
// - access error blocks command launch
// - erased flag set by verify, cleared at launch
// - verify-error set on failed verify in special mode, blocks launch
// - idle flag shows no operation active
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module fspg_top import fspg_pkg::*; #(
  parameter logic [REG_W-1:0] PROT_RESET = 8'hFF,
  parameter logic [15:0]      TRANS_HI   = 16'h8848
) (
  // clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // axi4-lite write
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [AXI_AW-1:0] awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [AXI_DW-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic      [1:0]        bresp,
  // axi4-lite read
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [AXI_AW-1:0] araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic      [AXI_DW-1:0] rdata,
  output logic      [1:0]        rresp,
  // chip mode and engine events
  input  wire logic              special_mode,
  input  wire logic              flash_word_wr,
  input  wire logic              cmd_fetched,
  input  wire logic              all_done,
  input  wire logic              engine_active,
  input  wire logic              prot_hit,
  input  wire logic              stop_req,
  input  wire logic              verify_done,
  input  wire logic              verify_blank,
  // towards the engine and the cpu
  output logic                   cmd_launch,
  output logic      [REG_W-1:0]  command_code_bits,
  output logic      [REG_W-1:0]  protection_config,
  output logic                   irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    fspg_seq_t        seq;
    logic             bef;
    logic             cdone;
    logic             protection_violation_flag;
    logic             access_error_flag;
    logic             blank;
    logic             fail;
    logic             beie;
    logic             cdie;
    logic [REG_W-1:0] cmd;
    logic             launch;
  } fspg_core_t;

  localparam fspg_core_t CORE_RESET = '{
    seq: SEQ_IDLE, bef: 1'b1, cdone: 1'b1, protection_violation_flag: 1'b0, access_error_flag: 1'b0,
    blank: 1'b0, fail: 1'b0, beie: 1'b0, cdie: 1'b0, cmd: 8'h00,
    launch: 1'b0};

  fspg_core_t s_q, s_d;
  fspg_reg_if rb ();

  logic             w_cfg;
  logic             w_prot;
  logic             w_stat;
  logic             w_cmd;
  logic             blocked;
  logic             prot_ok;
  logic [REG_W-1:0] cmd_new;

  // ****************************************************************
  // submodules
  // ****************************************************************
  fspg_axil_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .bvalid  (bvalid),
    .bready  (bready),
    .bresp   (bresp),
    .arvalid (arvalid),
    .arready (arready),
    .araddr  (araddr),
    .rvalid  (rvalid),
    .rready  (rready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rb      (rb)
  );

  fspg_prot_filter #(
    .PROT_RESET (PROT_RESET),
    .TRANS_HI   (TRANS_HI)
  ) u_prot (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .wr_en   (w_prot),
    .wdata   (rb.wdata),
    .prot_q  (protection_config),
    .allowed (prot_ok)
  );

  // ****************************************************************
  // write decode
  // ****************************************************************
  assign w_cfg   = rb.wr && (rb.idx_w == IDX_CFG);
  assign w_prot  = rb.wr && (rb.idx_w == IDX_PROT);
  assign w_stat  = rb.wr && (rb.idx_w == IDX_STAT);
  assign w_cmd   = rb.wr && (rb.idx_w == IDX_CMD);
  assign cmd_new = rb.wdata & CMD_MASK;
  // any pending error keeps the buffer from being launched
  assign blocked = s_q.protection_violation_flag || s_q.access_error_flag || s_q.fail;

  // ****************************************************************
  // flag and sequence update
  // ****************************************************************
  // clears come before the engine event sets, so an engine set wins a clash
  always_comb begin
    s_d        = s_q;
    s_d.launch = 1'b0;
    if (w_cfg) begin
      s_d.beie = rb.wdata[B_BEIE];
      s_d.cdie = rb.wdata[B_CDIE];
    end
    // a flash word write opens a sequence; outside idle it sets access error
    if (flash_word_wr) begin
      if (s_q.seq == SEQ_IDLE) begin
        s_d.seq = SEQ_ADDR;
      end else begin
        s_d.seq    = SEQ_IDLE;
        s_d.access_error_flag = 1'b1;
      end
    end
    if (w_cmd) begin
      s_d.cmd = cmd_new;
      if (s_q.seq == SEQ_ADDR &&
          cmd_new inside {CMD_VERIFY, CMD_PROG, CMD_SECTOR, CMD_MASS}) begin
        s_d.seq = SEQ_CMD;
      end else begin
        s_d.seq    = SEQ_IDLE;
        s_d.access_error_flag = 1'b1;
      end
    end
    if (w_stat) begin
      if (rb.wdata[B_PROTECTION_VIOLATION_FLAG]) begin
        s_d.protection_violation_flag = 1'b0;
      end
      if (rb.wdata[B_ACC]) begin
        s_d.access_error_flag = 1'b0;
      end
      if (special_mode && rb.wdata[B_FAIL]) begin
        s_d.fail = 1'b0;
      end
      if (rb.wdata[B_BEF]) begin
        if (s_q.seq == SEQ_CMD && !blocked) begin
          s_d.bef    = 1'b0;
          s_d.cdone  = 1'b0;
          s_d.blank  = 1'b0;
          s_d.seq    = SEQ_IDLE;
          s_d.launch = 1'b1;
        end else if (s_q.seq == SEQ_ADDR) begin
          s_d.seq    = SEQ_IDLE;
          s_d.access_error_flag = 1'b1;
        end
      end else if (s_q.seq != SEQ_IDLE) begin
        s_d.seq    = SEQ_IDLE;
        s_d.access_error_flag = 1'b1;
      end
    end
    // engine events
    if (cmd_fetched) begin
      s_d.bef = 1'b1;
    end
    if (all_done) begin
      s_d.cdone = 1'b1;
    end
    if (prot_hit) begin
      s_d.protection_violation_flag = 1'b1;
    end
    if (stop_req && !s_q.cdone) begin
      s_d.access_error_flag = 1'b1;
    end
    if (verify_done && verify_blank) begin
      s_d.blank = 1'b1;
    end
    if (verify_done && !verify_blank && special_mode) begin
      s_d.fail = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= CORE_RESET;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  // hidden bits read zero; status bits 1 and 0 only in special mode
  always_comb begin
    rb.rdata = '0;
    unique case (rb.idx_r)
      IDX_CFG: begin
        rb.rdata[B_BEIE] = s_q.beie;
        rb.rdata[B_CDIE] = s_q.cdie;
      end
      IDX_PROT: begin
        rb.rdata = protection_config;
      end
      IDX_STAT: begin
        rb.rdata[B_BEF]   = s_q.bef;
        rb.rdata[B_CDONE] = s_q.cdone;
        rb.rdata[B_PROTECTION_VIOLATION_FLAG] = s_q.protection_violation_flag;
        rb.rdata[B_ACC]   = s_q.access_error_flag;
        rb.rdata[B_BLANK] = s_q.blank;
        rb.rdata[B_FAIL]  = special_mode && s_q.fail;
        rb.rdata[B_IDLE]  = special_mode && !engine_active;
      end
      IDX_CMD: begin
        rb.rdata = s_q.cmd;
      end
      default: begin
        rb.rdata = '0;
      end
    endcase
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // interrupt is a level, held as long as flag and enable are both set
  assign irq = (s_q.bef && s_q.beie) || (s_q.cdone && s_q.cdie);
  assign cmd_launch        = s_q.launch;
  assign command_code_bits = s_q.cmd;

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_prot_refused: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && w_prot && !prot_ok |=> $stable(protection_config))
    else $error("refused protection write changed the register");

  a_prot_taken: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && w_prot && prot_ok |=> protection_config == $past(rb.wdata))
    else $error("allowed protection write not stored");

  a_prot_readback: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rb.rd && rb.idx_r == IDX_PROT |=> rvalid && rdata[REG_W-1:0] == $past(protection_config))
    else $error("protection read shows wrong value");

  a_normal_hidden: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rb.rd && rb.idx_r == IDX_STAT && !special_mode |=> rdata[B_FAIL] == 1'b0
      && rdata[B_IDLE] == 1'b0 && rdata[3] == 1'b0)
    else $error("hidden status bits read nonzero");

  a_special_idle: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rb.rd && rb.idx_r == IDX_STAT && special_mode |=> rdata[B_IDLE] == !$past(engine_active))
    else $error("idle bit does not follow engine activity");

  a_launch_gate: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(cmd_launch) |-> !$past(s_q.protection_violation_flag) && !$past(s_q.access_error_flag) && !$past(s_q.fail))
    else $error("command launched while an error flag was set");

  a_launch_clears: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cmd_launch && !$past(cmd_fetched) && !$past(all_done) |-> !s_q.bef && !s_q.cdone)
    else $error("launch did not clear buffer-empty and command-done");

  a_abort_error: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && w_stat && !rb.wdata[B_BEF] && s_q.seq != SEQ_IDLE |=> s_q.access_error_flag ##0 s_q.seq == SEQ_IDLE)
    else $error("zero to buffer-empty mid-sequence did not abort");

  a_protection_violation_flag_set: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && prot_hit |=> s_q.protection_violation_flag)
    else $error("protection hit did not set the violation flag");

  a_stop_error: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && stop_req && !s_q.cdone |=> s_q.access_error_flag)
    else $error("stop during a command did not set access error");

  a_irq_level: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_q.bef && s_q.beie |-> irq)
    else $error("buffer-empty interrupt missing");

  a_blank_clear: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(cmd_launch) && !$past(verify_done) |-> !s_q.blank)
    else $error("erased flag survived a launch");

endmodule
`default_nettype wire

/* tb/fspg_engine_model.sv */
// program/erase engine stand-in for the status guard
// assumes cmd_launch is a one-cycle pulse on aclk
`timescale 1ns/1ps
`default_nettype none
module fspg_engine_model (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // from the guard
  input  wire logic cmd_launch,
  // engine events
  output logic      cmd_fetched,
  output logic      all_done,
  output logic      engine_active
);
  // ****************************************************************
  // slow engine: gives the bench time to see cleared flags
  // ****************************************************************
  int cnt;
  always @(posedge aclk) begin
    cmd_fetched <= 1'b0;
    all_done <= 1'b0;
    if (!aresetn) begin
      cnt <= 0;
      engine_active <= 1'b0;
    end else if (cmd_launch) begin
      cnt <= 1;
    end else if (cnt != 0) begin
      cnt <= (cnt == 40) ? 0 : cnt + 1;
      if (cnt == 20) begin
        cmd_fetched <= 1'b1; // buffer taken, work starts
        engine_active <= 1'b1;
      end
      if (cnt == 40) begin
        all_done <= 1'b1; // only once nothing is pending
        engine_active <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the flash status and protection guard
// assumes the design files under src and the engine stand-in
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", nm, e, s); end end
module tb;
  import fspg_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic aclk, aresetn, awvalid, wvalid, arvalid, awready, wready, bvalid;
  logic arready, rvalid, special_mode, verify_blank, cmd_launch, irq;
  logic cmd_fetched, all_done, engine_active;
  logic [3:0] ev;  // event pulses: stop, protection hit, verify, word write
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [AXI_DW-1:0] wdata, rdata, d;
  logic [1:0]        bresp, rresp, r;
  logic [7:0]        command_code_bits, protection_config;
  int                failures, comparisons, launches, i;
  localparam logic [7:0] A_CFG  = {2'h0, IDX_CFG, 2'h0};
  localparam logic [7:0] A_PROT = {2'h0, IDX_PROT, 2'h0};
  localparam logic [7:0] A_STAT = {2'h0, IDX_STAT, 2'h0};
  localparam logic [7:0] A_CMD  = {2'h0, IDX_CMD, 2'h0};
  localparam logic [3:0] P_WORD = 4'h1, P_VER = 4'h2, P_HIT = 4'h4, P_STOP = 4'h8;
  logic [7:0] pw[5] = '{8'h7B, 8'hFB, 8'hFF, 8'hDB, 8'hDF};
  logic [7:0] pe[5] = '{8'hFF, 8'hFB, 8'hFB, 8'hDB, 8'hDB};
  logic [7:0] ie[3] = '{8'h80, 8'h40, 8'h00};

  fspg_top fspg_top_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(1'b1),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(1'b1), .rdata(rdata), .rresp(rresp),
    .special_mode(special_mode), .flash_word_wr(ev[0]),
    .cmd_fetched(cmd_fetched), .all_done(all_done), .engine_active(engine_active),
    .prot_hit(ev[2]), .stop_req(ev[3]), .verify_done(ev[1]),
    .verify_blank(verify_blank), .cmd_launch(cmd_launch),
    .command_code_bits(command_code_bits), .protection_config(protection_config),
    .irq(irq));
  fspg_engine_model fspg_engine_model_inst (.aclk(aclk), .aresetn(aresetn),
    .cmd_launch(cmd_launch), .cmd_fetched(cmd_fetched), .all_done(all_done),
    .engine_active(engine_active));

  // ****************************************************************
  // clock, launch counter, bus tasks
  // ****************************************************************
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (cmd_launch === 1'b1) launches++;
  end
  task automatic give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // write: both channels offered together, released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    int n;
    logic ta, tw, tb_;
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      #1 ta = awvalid & awready;
      tw = wvalid & wready;
      tb_ = bvalid;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb_) break;
    end
    if (n == 50) begin failures++; give_verdict(); end
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    logic t, v;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      #1 t = arvalid & arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (t) arvalid <= 1'b0;
      if (v) break;
    end
    if (n == 50) begin failures++; give_verdict(); end
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e, input string nm);
    rd(a);
    `CHK(nm, {24'h0, e}, d)
  endtask
  task automatic pulse(input logic [3:0] m);
    ev <= m;
    @(posedge aclk);
    ev <= 4'h0;
    @(posedge aclk);
  endtask
  task automatic launch_try();
    pulse(P_WORD);
    wr(A_CMD, CMD_PROG);
    wr(A_STAT, 8'h80);
    repeat (3) @(posedge aclk);
  endtask

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    {aresetn, awvalid, wvalid, arvalid, special_mode, ev} = '0;
    {verify_blank, awaddr, araddr, wdata} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(A_STAT, 8'hC0, "status");
    rd(8'h00);
    `CHK("unmapped resp", RESP_SLVERR, r)
    for (i = 0; i < 5; i++) begin
      wr(A_PROT, pw[i]);
      chk(A_PROT, pe[i], "prot");
      `CHK("prot pin", pe[i], protection_config)
    end
    $display("test protection done");
    foreach (ie[i]) begin
      wr(A_CFG, ie[i]);
      @(posedge aclk);
      `CHK("irq", ie[i] != 8'h00, irq)
    end
    wr(A_STAT, 8'h47);
    chk(A_STAT, 8'hC0, "status");
    verify_blank <= 1'b1;
    pulse(P_VER);
    wr(A_STAT, 8'h04);
    chk(A_STAT, 8'hC4, "status");
    special_mode <= 1'b1;
    verify_blank <= 1'b0;
    pulse(P_VER);
    chk(A_STAT, 8'hC7, "status");
    special_mode <= 1'b0;
    chk(A_STAT, 8'hC4, "status");
    special_mode <= 1'b1;
    wr(A_STAT, 8'h02);
    chk(A_STAT, 8'hC5, "status");
    special_mode <= 1'b0;
    $display("test flags done");
    pulse(P_HIT);
    chk(A_STAT, 8'hE4, "status");
    launch_try();
    `CHK("launches", 0, launches)
    // a zero to buffer-empty here would abort the held sequence
    wr(A_STAT, 8'hA0);
    chk(A_STAT, 8'hC4, "status");
    wr(A_STAT, 8'h80);
    repeat (3) @(posedge aclk);
    `CHK("launches", 1, launches)
    `CHK("cmd", CMD_PROG, command_code_bits)
    chk(A_STAT, 8'h00, "status");
    repeat (60) @(posedge aclk);
    chk(A_STAT, 8'hC0, "status");
    pulse(P_WORD);
    wr(A_STAT, 8'h00);
    chk(A_STAT, 8'hD0, "status");
    launch_try();
    `CHK("launches", 1, launches)
    wr(A_STAT, 8'h90);
    chk(A_STAT, 8'hC0, "status");
    wr(A_STAT, 8'h80);
    pulse(P_STOP);
    chk(A_STAT, 8'h10, "status");
    `CHK("launches", 2, launches)
    $display("test launch done");
    give_verdict();
  end
endmodule
`default_nettype wire
